// ===== core/prcr_pll_ratio_regs.v
// pll ratio configuration registers with registered effective settings
//
// Operation
// - prescale code zero divides by 256, any other code divides by itself.
// - with auto detection on, programmed divider and multipliers are ignored.
// - integer multiplier is top bit 7 of 0x36 above the 0x38 byte.
// - fraction is bits 5..0 of 0x36 above the 0x37 byte.
// - bit 6 of 0x36 set halves the pll divided clock, clear passes it.
// - reset gives integer low byte 8, prescale 1, fraction and halve zero.
`timescale 1ns/1ps
`include "prcr_consts.vh"

module prcr_pll_ratio_regs (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // control register port
    input wire [7:0] reg_addr_in,
    input wire reg_wr_en_in,
    input wire [7:0] reg_wr_data_in,
    input wire reg_rd_en_in,
    output reg [7:0] reg_rd_data_out,
    output reg reg_rd_hit_out,
    // clock detection
    input wire auto_detect_en_in,
    input wire [7:0] auto_prescale_code_in,
    input wire [8:0] auto_int_mult_in,
    input wire [13:0] auto_frac_mult_in,
    // settings towards the pll
    output reg [8:0] pll_prescale_div_out,
    output reg [8:0] pll_int_mult_out,
    output reg [13:0] pll_frac_mult_out,
    output reg [22:0] pll_ratio_x10000_out,
    output reg divided_clock_halve_out,
    output reg pll_config_reserved_out,
    // raw contents of the neighbouring divider register
    output reg [7:0] clock_divider_values_out
);

    // register storage
    reg [7:0] pll_prescale_divider_reg;
    reg [7:0] pll_multiplier_high_bits_reg;
    reg [7:0] pll_fraction_low_byte_reg;
    reg [7:0] pll_integer_low_byte_reg;
    reg [5:0] clock_divider_values_reg;

    reg [7:0] rd_data_next;
    reg rd_hit_next;

    wire integer_mult_top_bit;
    wire divided_clock_halve;
    wire [5:0] fraction_mult_top_bits;
    wire [8:0] prog_int_mult;
    wire [13:0] prog_frac_mult;
    wire [8:0] calc_prescale_div;
    wire [8:0] calc_int_mult;
    wire [13:0] calc_frac_mult;
    wire [22:0] calc_ratio;
    wire calc_reserved;

    // write strobes, one per register
    wire wr_mapped;
    wire wr_prescale;
    wire wr_mult_high;
    wire wr_frac_low;
    wire wr_int_low;
    wire wr_clk_divs;

    // reset images of the effective settings, taken from the register reset values
    localparam [7:0] RST_MULT_HIGH = `PRCR_RST_MULT_HIGH;
    localparam [7:0] RST_CLK_DIVS = `PRCR_RST_CLK_DIVS;
    // reset prescale code is nonzero, so the divisor is the code itself
    localparam [8:0] RST_PRESCALE_DIV = {1'b0, `PRCR_RST_PRESCALE};
    localparam [8:0] RST_INT_MULT = {RST_MULT_HIGH[`PRCR_INT_TOP_BIT], `PRCR_RST_INT_LOW};
    localparam [13:0] RST_FRAC_MULT = {RST_MULT_HIGH[`PRCR_FRAC_TOP_MSB:`PRCR_FRAC_TOP_LSB], `PRCR_RST_FRAC_LOW};
    localparam [22:0] RST_RATIO = {14'h0000, RST_INT_MULT} * `PRCR_FRAC_SCALE + {9'h000, RST_FRAC_MULT};

    // shared address decode for the write and read paths
    function addr_is_mapped;
        input [7:0] addr;
        begin
            if (addr == `PRCR_ADDR_PRESCALE) begin
                addr_is_mapped = 1'b1;
            end else if (addr == `PRCR_ADDR_MULT_HIGH) begin
                addr_is_mapped = 1'b1;
            end else if (addr == `PRCR_ADDR_FRAC_LOW) begin
                addr_is_mapped = 1'b1;
            end else if (addr == `PRCR_ADDR_INT_LOW) begin
                addr_is_mapped = 1'b1;
            end else if (addr == `PRCR_ADDR_CLK_DIVS) begin
                addr_is_mapped = 1'b1;
            end else begin
                addr_is_mapped = 1'b0;
            end
        end
    endfunction

    assign integer_mult_top_bit = pll_multiplier_high_bits_reg[`PRCR_INT_TOP_BIT];
    assign divided_clock_halve = pll_multiplier_high_bits_reg[`PRCR_HALVE_BIT];
    assign fraction_mult_top_bits = pll_multiplier_high_bits_reg[`PRCR_FRAC_TOP_MSB:`PRCR_FRAC_TOP_LSB];
    assign prog_int_mult = {integer_mult_top_bit, pll_integer_low_byte_reg};
    assign prog_frac_mult = {fraction_mult_top_bits, pll_fraction_low_byte_reg};

    // unmapped addresses raise no strobe, so such writes are dropped
    assign wr_mapped = reg_wr_en_in && addr_is_mapped(reg_addr_in);
    assign wr_prescale = wr_mapped && (reg_addr_in == `PRCR_ADDR_PRESCALE);
    assign wr_mult_high = wr_mapped && (reg_addr_in == `PRCR_ADDR_MULT_HIGH);
    assign wr_frac_low = wr_mapped && (reg_addr_in == `PRCR_ADDR_FRAC_LOW);
    assign wr_int_low = wr_mapped && (reg_addr_in == `PRCR_ADDR_INT_LOW);
    assign wr_clk_divs = wr_mapped && (reg_addr_in == `PRCR_ADDR_CLK_DIVS);

    // register writes, one block per register
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pll_prescale_divider_reg <= `PRCR_RST_PRESCALE;
        end else if (wr_prescale) begin
            pll_prescale_divider_reg <= reg_wr_data_in;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pll_multiplier_high_bits_reg <= `PRCR_RST_MULT_HIGH;
        end else if (wr_mult_high) begin
            pll_multiplier_high_bits_reg <= reg_wr_data_in;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pll_fraction_low_byte_reg <= `PRCR_RST_FRAC_LOW;
        end else if (wr_frac_low) begin
            pll_fraction_low_byte_reg <= reg_wr_data_in;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pll_integer_low_byte_reg <= `PRCR_RST_INT_LOW;
        end else if (wr_int_low) begin
            pll_integer_low_byte_reg <= reg_wr_data_in;
        end
    end

    // low two bits are reserved and keep reading zero
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            clock_divider_values_reg <= RST_CLK_DIVS[`PRCR_CLK_DIVS_MSB:`PRCR_CLK_DIVS_LSB];
        end else if (wr_clk_divs) begin
            clock_divider_values_reg <= reg_wr_data_in[`PRCR_CLK_DIVS_MSB:`PRCR_CLK_DIVS_LSB];
        end
    end

    // read mux; a write in the same cycle is not yet visible
    always @* begin
        rd_data_next = `PRCR_UNMAPPED_DATA;
        rd_hit_next = addr_is_mapped(reg_addr_in);
        if (reg_addr_in == `PRCR_ADDR_PRESCALE) begin
            rd_data_next = pll_prescale_divider_reg;
        end else if (reg_addr_in == `PRCR_ADDR_MULT_HIGH) begin
            rd_data_next = pll_multiplier_high_bits_reg;
        end else if (reg_addr_in == `PRCR_ADDR_FRAC_LOW) begin
            rd_data_next = pll_fraction_low_byte_reg;
        end else if (reg_addr_in == `PRCR_ADDR_INT_LOW) begin
            rd_data_next = pll_integer_low_byte_reg;
        end else if (reg_addr_in == `PRCR_ADDR_CLK_DIVS) begin
            rd_data_next = {clock_divider_values_reg, 2'b00};
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rd_data_out <= 8'h00;
            reg_rd_hit_out <= 1'b0;
        end else if (reg_rd_en_in) begin
            reg_rd_data_out <= rd_data_next;
            reg_rd_hit_out <= rd_hit_next;
        end else begin
            // data holds until the next read, the hit flag is a pulse
            reg_rd_hit_out <= 1'b0;
        end
    end

    prcr_ratio_calc u_ratio_calc (
        .auto_detect_en_in(auto_detect_en_in),
        .prog_prescale_code_in(pll_prescale_divider_reg),
        .prog_int_mult_in(prog_int_mult),
        .prog_frac_mult_in(prog_frac_mult),
        .auto_prescale_code_in(auto_prescale_code_in),
        .auto_int_mult_in(auto_int_mult_in),
        .auto_frac_mult_in(auto_frac_mult_in),
        .prescale_div_out(calc_prescale_div),
        .int_mult_out(calc_int_mult),
        .frac_mult_out(calc_frac_mult),
        .ratio_x10000_out(calc_ratio),
        .prog_reserved_out(calc_reserved)
    );

    // registered so the analog side never sees decode glitches
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pll_prescale_div_out <= RST_PRESCALE_DIV;
            pll_int_mult_out <= RST_INT_MULT;
            pll_frac_mult_out <= RST_FRAC_MULT;
            pll_ratio_x10000_out <= RST_RATIO;
            divided_clock_halve_out <= RST_MULT_HIGH[`PRCR_HALVE_BIT];
            pll_config_reserved_out <= 1'b0;
            clock_divider_values_out <= `PRCR_RST_CLK_DIVS;
        end else begin
            pll_prescale_div_out <= calc_prescale_div;
            pll_int_mult_out <= calc_int_mult;
            pll_frac_mult_out <= calc_frac_mult;
            pll_ratio_x10000_out <= calc_ratio;
            divided_clock_halve_out <= divided_clock_halve;
            pll_config_reserved_out <= calc_reserved;
            clock_divider_values_out <= {clock_divider_values_reg, 2'b00};
        end
    end

endmodule // prcr_pll_ratio_regs

// ===== core/prcr_consts.vh
// constants for the pll ratio configuration register block
`ifndef PRCR_CONSTS_VH
`define PRCR_CONSTS_VH

// register offsets on the control port
`define PRCR_ADDR_PRESCALE 8'h35
`define PRCR_ADDR_MULT_HIGH 8'h36
`define PRCR_ADDR_FRAC_LOW 8'h37
`define PRCR_ADDR_INT_LOW 8'h38
`define PRCR_ADDR_CLK_DIVS 8'h39

// reset values
`define PRCR_RST_PRESCALE 8'h01
`define PRCR_RST_MULT_HIGH 8'h00
`define PRCR_RST_FRAC_LOW 8'h00
`define PRCR_RST_INT_LOW 8'h08
`define PRCR_RST_CLK_DIVS 8'h20

// field positions in the multiplier high bits register
`define PRCR_INT_TOP_BIT 7
`define PRCR_HALVE_BIT 6
`define PRCR_FRAC_TOP_MSB 5
`define PRCR_FRAC_TOP_LSB 0

// writable part of the clock divider values register
`define PRCR_CLK_DIVS_MSB 7
`define PRCR_CLK_DIVS_LSB 2

// value decoding
`define PRCR_PRESCALE_ZERO_VALUE 9'h100
`define PRCR_FRAC_SCALE 23'h002710
`define PRCR_FRAC_MAX 14'h270f
`define PRCR_INT_RESERVED 9'h000

// answer for an unmapped read
`define PRCR_UNMAPPED_DATA 8'h00

`endif

// ===== core/prcr_ratio_calc.v
// selects programmed or detected pll settings and works out the ratio
`timescale 1ns/1ps
`include "prcr_consts.vh"

module prcr_ratio_calc (
    // control
    input wire auto_detect_en_in,
    // programmed fields
    input wire [7:0] prog_prescale_code_in,
    input wire [8:0] prog_int_mult_in,
    input wire [13:0] prog_frac_mult_in,
    // detected fields
    input wire [7:0] auto_prescale_code_in,
    input wire [8:0] auto_int_mult_in,
    input wire [13:0] auto_frac_mult_in,
    // results
    output reg [8:0] prescale_div_out,
    output reg [8:0] int_mult_out,
    output reg [13:0] frac_mult_out,
    output reg [22:0] ratio_x10000_out,
    output reg prog_reserved_out
);

    reg [7:0] code_sel;

    always @* begin
        // detection overrides every programmed ratio field
        if (auto_detect_en_in) begin
            code_sel = auto_prescale_code_in;
            int_mult_out = auto_int_mult_in;
            frac_mult_out = auto_frac_mult_in;
        end else begin
            code_sel = prog_prescale_code_in;
            int_mult_out = prog_int_mult_in;
            frac_mult_out = prog_frac_mult_in;
        end
        // code zero stands for the largest divider
        if (code_sel == 8'h00) begin
            prescale_div_out = `PRCR_PRESCALE_ZERO_VALUE;
        end else begin
            prescale_div_out = {1'b0, code_sel};
        end
        // fout = fref / p * (j + d / 10000), kept as j*10000 + d
        ratio_x10000_out = {14'h0000, int_mult_out} * `PRCR_FRAC_SCALE + {9'h000, frac_mult_out};
        // flags software breaking its side; the value is still passed through
        prog_reserved_out = !auto_detect_en_in &&
            ((prog_int_mult_in == `PRCR_INT_RESERVED) || (prog_frac_mult_in > `PRCR_FRAC_MAX));
    end

endmodule // prcr_ratio_calc

// ===== testbench/prcr_pll_ratio_props.sv
// assertion checker for the pll ratio configuration registers
`timescale 1ns/1ps
module prcr_ratio_props (
    // clock and reset
    input logic clk_in,
    input logic rst_in,
    // control register port
    input logic [7:0] reg_addr_in,
    input logic reg_wr_en_in,
    input logic [7:0] reg_wr_data_in,
    input logic reg_rd_en_in,
    input logic [7:0] reg_rd_data_out,
    input logic reg_rd_hit_out,
    // clock detection
    input logic auto_detect_en_in,
    input logic [7:0] auto_prescale_code_in,
    input logic [8:0] auto_int_mult_in,
    input logic [13:0] auto_frac_mult_in,
    // settings towards the pll
    input logic [8:0] pll_prescale_div_out,
    input logic [8:0] pll_int_mult_out,
    input logic [13:0] pll_frac_mult_out,
    input logic [22:0] pll_ratio_x10000_out,
    input logic divided_clock_halve_out,
    input logic pll_config_reserved_out,
    input logic [7:0] clock_divider_values_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire mapped = reg_addr_in >= 8'h35 && reg_addr_in <= 8'h39;
    sequence s_wr_pre;
        reg_wr_en_in && reg_addr_in == 8'h35 && !auto_detect_en_in;
    endsequence
    // programmed value only counts while detection stays off
    sequence s_pre_held;
        s_wr_pre ##1 !auto_detect_en_in;
    endsequence
    // write, one idle edge, then read of the same register
    sequence s_wr_then_rd;
        reg_wr_en_in && reg_addr_in == 8'h35 ##1 !reg_wr_en_in
            ##1 reg_rd_en_in && !reg_wr_en_in && reg_addr_in == 8'h35;
    endsequence
    a_prescale_decode: assert property (s_pre_held |=> pll_prescale_div_out ==
        ($past(reg_wr_data_in, 2) == 8'h00 ? 9'h100 : {1'b0, $past(reg_wr_data_in, 2)}))
        else $error("prescale divisor does not follow written code");
    a_auto_override: assert property (auto_detect_en_in |=> pll_int_mult_out == $past(auto_int_mult_in)
        && pll_frac_mult_out == $past(auto_frac_mult_in)) else $error("detected multipliers not used");
    a_auto_no_flag: assert property (auto_detect_en_in |=> !pll_config_reserved_out)
        else $error("reserved flag raised under detection");
    a_halve_follow: assert property (reg_wr_en_in && reg_addr_in == 8'h36 |=> ##1
        divided_clock_halve_out == $past(reg_wr_data_in[6], 2)) else $error("halve bit not applied");
    a_ratio_sum: assert property (pll_ratio_x10000_out == pll_int_mult_out * 23'h002710 + pll_frac_mult_out)
        else $error("ratio disagrees with multipliers");
    a_read_back: assert property (s_wr_then_rd |=> reg_rd_data_out == $past(reg_wr_data_in, 3))
        else $error("read does not return last write");
    a_int_low_apply: assert property (reg_wr_en_in && reg_addr_in == 8'h38 ##1 !auto_detect_en_in |=>
        pll_int_mult_out[7:0] == $past(reg_wr_data_in, 2)) else $error("integer low byte not applied");
    a_frac_low_apply: assert property (reg_wr_en_in && reg_addr_in == 8'h37 ##1 !auto_detect_en_in |=>
        pll_frac_mult_out[7:0] == $past(reg_wr_data_in, 2)) else $error("fraction low byte not applied");
    a_mapped_hit: assert property (reg_rd_en_in && mapped |=> reg_rd_hit_out)
        else $error("mapped read without hit");
    a_unmapped_zero: assert property (reg_rd_en_in && !mapped |=> !reg_rd_hit_out && reg_rd_data_out == 8'h00)
        else $error("unmapped read not empty");
    a_hit_pulse: assert property (!reg_rd_en_in |=> !reg_rd_hit_out)
        else $error("hit without read");
    a_divs_low_zero: assert property (clock_divider_values_out[1:0] == 2'b00)
        else $error("reserved divider bits set");
endmodule // prcr_ratio_props
bind prcr_pll_ratio_regs prcr_ratio_props props_u (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_en_in(reg_wr_en_in),
    .reg_wr_data_in(reg_wr_data_in),
    .reg_rd_en_in(reg_rd_en_in),
    .reg_rd_data_out(reg_rd_data_out),
    .reg_rd_hit_out(reg_rd_hit_out),
    .auto_detect_en_in(auto_detect_en_in),
    .auto_prescale_code_in(auto_prescale_code_in),
    .auto_int_mult_in(auto_int_mult_in),
    .auto_frac_mult_in(auto_frac_mult_in),
    .pll_prescale_div_out(pll_prescale_div_out),
    .pll_int_mult_out(pll_int_mult_out),
    .pll_frac_mult_out(pll_frac_mult_out),
    .pll_ratio_x10000_out(pll_ratio_x10000_out),
    .divided_clock_halve_out(divided_clock_halve_out),
    .pll_config_reserved_out(pll_config_reserved_out),
    .clock_divider_values_out(clock_divider_values_out)
);

// ===== testbench/prcr_pll_ratio_regs_tb.sv
// self-checking bench for the pll ratio configuration registers
`timescale 1ns/1ps
module prcr_pll_ratio_regs_tb;
    logic clk_in = 0, rst_in = 1, reg_wr_en_in = 0, reg_rd_en_in = 0, auto_detect_en_in = 0;
    logic [7:0] reg_addr_in = 8'h00, reg_wr_data_in = 8'h00, auto_prescale_code_in = 8'h00;
    logic [7:0] reg_rd_data_out, clock_divider_values_out;
    logic [8:0] auto_int_mult_in = 9'h000, pll_prescale_div_out, pll_int_mult_out;
    logic [13:0] auto_frac_mult_in = 14'h0000, pll_frac_mult_out;
    logic [22:0] pll_ratio_x10000_out;
    logic reg_rd_hit_out, divided_clock_halve_out, pll_config_reserved_out;
    int n_mismatch = 0, comparisons = 0;
    prcr_pll_ratio_regs dut_u (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wr_en_in(reg_wr_en_in),
        .reg_wr_data_in(reg_wr_data_in),
        .reg_rd_en_in(reg_rd_en_in),
        .reg_rd_data_out(reg_rd_data_out),
        .reg_rd_hit_out(reg_rd_hit_out),
        .auto_detect_en_in(auto_detect_en_in),
        .auto_prescale_code_in(auto_prescale_code_in),
        .auto_int_mult_in(auto_int_mult_in),
        .auto_frac_mult_in(auto_frac_mult_in),
        .pll_prescale_div_out(pll_prescale_div_out),
        .pll_int_mult_out(pll_int_mult_out),
        .pll_frac_mult_out(pll_frac_mult_out),
        .pll_ratio_x10000_out(pll_ratio_x10000_out),
        .divided_clock_halve_out(divided_clock_halve_out),
        .pll_config_reserved_out(pll_config_reserved_out),
        .clock_divider_values_out(clock_divider_values_out)
    );
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    task automatic check(input string what, input logic [22:0] seen, input logic [22:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // an idle edge before each transfer keeps every strobe a single pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wr_data_in = d;
        reg_wr_en_in = 1;
        @(negedge clk_in);
        reg_wr_en_in = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_rd_en_in = 1;
        @(negedge clk_in);
        reg_rd_en_in = 0;
        check("rd_data", reg_rd_data_out, exp);
        check("rd_hit", reg_rd_hit_out, hit);
    endtask
    // settings land one edge after the register commits
    task automatic pll(input logic [8:0] p, input logic [8:0] j, input logic [13:0] d, input logic res);
        @(negedge clk_in);
        check("prescale", pll_prescale_div_out, p);
        check("int_mult", pll_int_mult_out, j);
        check("frac_mult", pll_frac_mult_out, d);
        check("ratio", pll_ratio_x10000_out, j * 23'h002710 + d);
        check("reserved", pll_config_reserved_out, res);
    endtask
    task automatic t_reset;
        logic [7:0] rv[5] = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h20};
        check("halve", divided_clock_halve_out, 1'b0);
        check("divs", clock_divider_values_out, 8'h20);
        pll(9'h001, 9'h008, 14'h0000, 1'b0);
        for (int i = 0; i < 5; i++) begin
            rd(8'(8'h35 + i), rv[i], 1'b1);
        end
    endtask
    task automatic t_rw;
        wr(8'h39, 8'hff);
        rd(8'h39, 8'hfc, 1'b1);
        wr(8'h34, 8'h5a);
        rd(8'h34, 8'h00, 1'b0);
        wr(8'h35, 8'ha5);
        rd(8'h35, 8'ha5, 1'b1);
        @(negedge clk_in);
        check("hit_pulse", reg_rd_hit_out, 1'b0);
        check("divs", clock_divider_values_out, 8'hfc);
    endtask
    task automatic t_prescale;
        wr(8'h35, 8'h00);
        pll(9'h100, 9'h008, 14'h0000, 1'b0);
        wr(8'h35, 8'hff);
        pll(9'h0ff, 9'h008, 14'h0000, 1'b0);
    endtask
    task automatic t_mult;
        wr(8'h36, 8'he7);
        wr(8'h37, 8'h0f);
        wr(8'h38, 8'hff);
        pll(9'h0ff, 9'h1ff, 14'h270f, 1'b0);
        check("halve", divided_clock_halve_out, 1'b1);
        wr(8'h36, 8'h28);
        wr(8'h37, 8'h10);
        pll(9'h0ff, 9'h0ff, 14'h2810, 1'b1);
        check("halve", divided_clock_halve_out, 1'b0);
        wr(8'h36, 8'h00);
        wr(8'h38, 8'h00);
        pll(9'h0ff, 9'h000, 14'h0010, 1'b1);
    endtask
    task automatic t_auto;
        auto_detect_en_in = 1;
        auto_int_mult_in = 9'h003;
        auto_frac_mult_in = 14'h0005;
        pll(9'h100, 9'h003, 14'h0005, 1'b0);
        wr(8'h36, 8'h40);
        pll(9'h100, 9'h003, 14'h0005, 1'b0);
        check("halve", divided_clock_halve_out, 1'b1);
        rd(8'h36, 8'h40, 1'b1);
        auto_detect_en_in = 0;
        pll(9'h0ff, 9'h000, 14'h0010, 1'b1);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_in);
        rst_in = 0;
        t_reset();
        t_rw();
        t_prescale();
        t_mult();
        t_auto();
        final_report();
    end
    // run needs about 60 cycles; far longer means a hang
    initial begin
        #20us;
        n_mismatch++;
        final_report();
    end
endmodule // prcr_pll_ratio_regs_tb
